/* pkg/drse_pkg.sv */
// Purpose: Constants and carrier types for the result status byte encoder
// Assumes: Single clock domain, synchronous active-low reset
// Notes: Bit positions of the three status bytes live here
package drse_pkg;

  localparam int DRSE_RESULT_BYTES = 3;
  localparam logic [6:0] DRSE_MAX_RECAL_STEPS = 7'h50;
  localparam logic [7:0] DRSE_LAST_SECTOR = 8'hFF;
  localparam logic [7:0] DRSE_BAD_CYL = 8'hFF;
  localparam logic [1:0] DRSE_INDEX_LIMIT = 2'h2;

  localparam logic [1:0] DRSE_CC_NORMAL = 2'h0;
  localparam logic [1:0] DRSE_CC_ABNORMAL = 2'h1;
  localparam logic [1:0] DRSE_CC_INVALID = 2'h2;
  localparam logic [1:0] DRSE_CC_POLLING = 2'h3;

  localparam int DRSE_B0_CC_LO = 6;
  localparam int DRSE_B0_SEEK = 5;
  localparam int DRSE_B0_EQUIP = 4;
  localparam int DRSE_B0_HEAD = 2;
  localparam int DRSE_B0_DRIVE_LO = 0;
  localparam int DRSE_B1_EOC = 7;
  localparam int DRSE_B1_CRC = 5;
  localparam int DRSE_B1_OVR = 4;
  localparam int DRSE_B1_NOSEC = 2;
  localparam int DRSE_B1_WP = 1;
  localparam int DRSE_B1_MARK = 0;
  localparam int DRSE_B2_DEL = 6;
  localparam int DRSE_B2_DCRC = 5;
  localparam int DRSE_B2_WCYL = 4;
  localparam int DRSE_B2_BAD = 1;
  localparam int DRSE_B2_DMARK = 0;

  // Command class reported by the command engine
  typedef enum logic [3:0] {
    DRSE_CMD_OTHER = 4'h0,
    DRSE_CMD_SEEK = 4'h1,
    DRSE_CMD_RECAL = 4'h2,
    DRSE_CMD_REL_SEEK = 4'h3,
    DRSE_CMD_READ = 4'h4,
    DRSE_CMD_READ_DEL = 4'h5,
    DRSE_CMD_READ_ID = 4'h6,
    DRSE_CMD_READ_TRACK = 4'h7,
    DRSE_CMD_WRITE = 4'h8,
    DRSE_CMD_WRITE_DEL = 4'h9,
    DRSE_CMD_FORMAT = 4'hA
  } drse_cmd_t;

  // Start of command and its context
  typedef struct packed {
    logic start;
    drse_cmd_t cmd;
    logic implied_seek;
    logic head;
    logic [1:0] drive;
  } drse_cmd_info_t;

  // Execution events from the command engine and data path
  typedef struct packed {
    logic step_pulse;
    logic step_out_past_zero;
    logic seek_complete;
    logic sector_past_end;
    logic id_crc_err;
    logic data_crc_err;
    logic service_late;
    logic sector_missing;
    logic id_read_fail;
    logic sequence_fail;
    logic id_mark_found;
    logic data_mark_missing;
    logic data_mark_seen;
    logic deleted_mark_seen;
    logic id_valid;
    logic [7:0] id_cyl;
    logic [7:0] sector_num;
  } drse_event_t;

  // End of command
  typedef struct packed {
    logic finish;
    logic invalid;
    logic poll_abort;
  } drse_end_t;

endpackage : drse_pkg

/* rtl/drse_status_encoder.sv */
// Purpose: Collects command outcome and builds three result-phase status bytes
// Assumes: Command engine pulses start/finish; host reads bytes via result sequence
// Notes: Drive pins are asynchronous and pass three flip-flops
// Summary of operation
// - Completion code 00 when command finished without error.
// - Completion code 01 when command started but failed.
// - Code 10 for invalid command, 11 for polling abort.
// - First byte bit 5 set on seek, recalibrate or implied seek done.
// - Equipment fault when track zero still low after 80 recalibrate steps.
// - Equipment fault when relative seek steps outward past track zero.
// - First byte bit 2 shows addressed head.
// - First byte bits 1..0 show selected drive.
// - Second byte bit 7 set on access beyond last sector, 255 max.
// - End-of-cylinder set when read or write ends without terminal count.
// - Second byte bit 5 set on ID or data field CRC error.
// - Second byte bit 4 set on service overrun or underrun.
// - Second byte bit 2 set on sector, ID or sequence not found.
// - Second byte bit 1 set if write-protect is high at any time during write or format.
// - Missing-mark set when no ID mark after two index pulses.
// - Missing-mark also set when no data or deleted data mark found.
// - Third byte bit 6 set on data mark type mismatch.
// - Third byte bit 5 set on data field CRC error.
// - Third byte bit 4 set when ID cylinder differs from internal.
// - Third byte bit 1 set when differing ID cylinder equals FF.
// - Third byte bit 0 set when no data mark of either kind found.
// - Status bytes reach host only as result bytes of a command.
`timescale 1ns/1ps

module drse_status_encoder (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire drse_pkg::drse_cmd_info_t cmd_info,
  input wire drse_pkg::drse_event_t exec_evt,
  input wire drse_pkg::drse_end_t cmd_end,
  input wire logic [7:0] internal_cyl,
  input wire logic track_zero_in,
  input wire logic write_protect_in,
  input wire logic index_pulse_in,
  input wire logic transfer_terminate_in,
  input wire logic result_rd,
  output logic [7:0] result_byte,
  output logic result_valid,
  output logic result_last,
  output logic busy
);
  import drse_pkg::*;

  typedef enum logic [2:0] {
    DRSE_IDLE = 3'b001,
    DRSE_EXEC = 3'b010,
    DRSE_RESULT = 3'b100
  } drse_state_t;

  typedef struct packed {
    // Sequencer and pin synchronisers
    drse_state_t state;
    logic [2:0] sync_tz;
    logic [2:0] sync_wp;
    logic [2:0] sync_ix;
    logic [2:0] sync_tc;

    // Settled pin levels and terminate history
    logic tz_level;
    logic wp_level;
    logic ix_level;
    logic tc_seen;

    // Context captured at command start
    drse_cmd_t cmd;
    logic implied_seek;
    logic head;
    logic [1:0] drive;

    // Execution counters
    logic [6:0] step_cnt;
    logic [1:0] index_cnt;
    logic id_mark_found;

    // Sticky status flags, cleared only at start
    logic seek_done_flag;
    logic equipment_fault_flag;
    logic end_of_cyl_flag;
    logic crc_fault_flag;
    logic overrun_flag;
    logic sector_not_found_flag;
    logic write_protect_hit_flag;
    logic mark_missing_flag;
    logic deleted_mark_seen_flag;
    logic data_field_crc_flag;
    logic cylinder_mismatch_flag;
    logic bad_track_flag;
    logic data_mark_missing_flag;

    // Assembled result bytes and read sequence
    logic [1:0] completion_code;
    logic [7:0] completion_status_byte;
    logic [7:0] transfer_error_status_byte;
    logic [7:0] media_mark_status_byte;
    logic [1:0] rd_idx;
    logic [7:0] result_byte;
    logic result_valid;
    logic result_last;
    logic busy;
  } drse_regs_t;

  drse_regs_t r;
  drse_regs_t next_r;

  // Decode helpers and synchroniser agreement
  logic is_write;
  logic is_rw;
  logic any_err;
  logic tz_agree;
  logic wp_agree;
  logic ix_agree;
  logic tc_agree;

  always_comb begin
    next_r = r;
    is_write = (r.cmd == DRSE_CMD_WRITE) || (r.cmd == DRSE_CMD_WRITE_DEL) || (r.cmd == DRSE_CMD_FORMAT);
    is_rw = is_write || (r.cmd == DRSE_CMD_READ) || (r.cmd == DRSE_CMD_READ_DEL) ||
            (r.cmd == DRSE_CMD_READ_TRACK);
    any_err = 1'b0;

    // Three-stage synchronisers; a change counts once stages two and three agree
    next_r.sync_tz = {r.sync_tz[1:0], track_zero_in};
    next_r.sync_wp = {r.sync_wp[1:0], write_protect_in};
    next_r.sync_ix = {r.sync_ix[1:0], index_pulse_in};
    next_r.sync_tc = {r.sync_tc[1:0], transfer_terminate_in};
    tz_agree = r.sync_tz[2] == r.sync_tz[1];
    wp_agree = r.sync_wp[2] == r.sync_wp[1];
    ix_agree = r.sync_ix[2] == r.sync_ix[1];
    tc_agree = r.sync_tc[2] == r.sync_tc[1];
    if (tz_agree) begin
      next_r.tz_level = r.sync_tz[2];
    end
    if (wp_agree) begin
      next_r.wp_level = r.sync_wp[2];
    end
    if (ix_agree) begin
      next_r.ix_level = r.sync_ix[2];
    end

    next_r.result_valid = 1'b0;
    next_r.result_last = 1'b0;

    unique case (r.state)
      DRSE_IDLE: begin
        next_r.busy = 1'b0;
        if (cmd_info.start) begin
          next_r = '0;
          // Keep synchroniser contents and settled levels across the clear; they hold for this cycle
          next_r.sync_tz = r.sync_tz;
          next_r.sync_wp = r.sync_wp;
          next_r.sync_ix = r.sync_ix;
          next_r.sync_tc = r.sync_tc;
          next_r.tz_level = r.tz_level;
          next_r.wp_level = r.wp_level;
          next_r.ix_level = r.ix_level;
          next_r.state = DRSE_EXEC;
          next_r.busy = 1'b1;
          next_r.cmd = cmd_info.cmd;
          next_r.implied_seek = cmd_info.implied_seek;
          next_r.head = cmd_info.head;
          next_r.drive = cmd_info.drive;
        end
      end
      DRSE_EXEC: begin
        // Terminate seen at any time during execution ends the transfer cleanly
        if (tc_agree && r.sync_tc[2]) begin
          next_r.tc_seen = 1'b1;
        end

        // Recalibrate gives up once the step limit passes with track zero low
        if (r.cmd == DRSE_CMD_RECAL && exec_evt.step_pulse && !r.tz_level) begin
          if (r.step_cnt == DRSE_MAX_RECAL_STEPS - 7'h01) begin
            next_r.equipment_fault_flag = 1'b1;
          end else begin
            next_r.step_cnt = r.step_cnt + 7'h01;
          end
        end

        if (r.cmd == DRSE_CMD_REL_SEEK && exec_evt.step_out_past_zero) begin
          next_r.equipment_fault_flag = 1'b1;
        end

        if (exec_evt.seek_complete && (r.cmd == DRSE_CMD_SEEK || r.cmd == DRSE_CMD_RECAL ||
            r.cmd == DRSE_CMD_REL_SEEK || (is_rw && r.implied_seek))) begin
          next_r.seek_done_flag = 1'b1;
        end

        if (exec_evt.sector_past_end && exec_evt.sector_num == DRSE_LAST_SECTOR) begin
          next_r.end_of_cyl_flag = 1'b1;
        end

        // Either CRC fault marks the second byte; data field faults the third too
        if (exec_evt.id_crc_err || exec_evt.data_crc_err) begin
          next_r.crc_fault_flag = 1'b1;
        end
        if (exec_evt.data_crc_err) begin
          next_r.data_field_crc_flag = 1'b1;
        end

        if (exec_evt.service_late) begin
          next_r.overrun_flag = 1'b1;
        end

        // Not-found faults count only for the command that can raise them
        if ((exec_evt.sector_missing && (r.cmd == DRSE_CMD_READ || r.cmd == DRSE_CMD_READ_DEL)) ||
            (exec_evt.id_read_fail && r.cmd == DRSE_CMD_READ_ID) ||
            (exec_evt.sequence_fail && r.cmd == DRSE_CMD_READ_TRACK)) begin
          next_r.sector_not_found_flag = 1'b1;
        end

        // Protect is a level, so protect already high at start also counts
        if (is_write && r.wp_level) begin
          next_r.write_protect_hit_flag = 1'b1;
        end

        // Missing ID mark needs two settled index edges with no mark between
        if (exec_evt.id_mark_found) begin
          next_r.id_mark_found = 1'b1;
        end
        if (ix_agree && r.sync_ix[2] && !r.ix_level && !r.id_mark_found && !exec_evt.id_mark_found) begin
          if (r.index_cnt == DRSE_INDEX_LIMIT - 2'h1) begin
            next_r.mark_missing_flag = 1'b1;
          end else begin
            next_r.index_cnt = r.index_cnt + 2'h1;
          end
        end

        if (exec_evt.data_mark_missing) begin
          next_r.mark_missing_flag = 1'b1;
          next_r.data_mark_missing_flag = 1'b1;
        end

        if ((r.cmd == DRSE_CMD_READ && exec_evt.deleted_mark_seen) ||
            (r.cmd == DRSE_CMD_READ_DEL && exec_evt.data_mark_seen)) begin
          next_r.deleted_mark_seen_flag = 1'b1;
        end

        if (exec_evt.id_valid && exec_evt.id_cyl != internal_cyl) begin
          next_r.cylinder_mismatch_flag = 1'b1;
          if (exec_evt.id_cyl == DRSE_BAD_CYL) begin
            next_r.bad_track_flag = 1'b1;
          end
        end

        // Terminate on the finishing edge itself still counts as seen
        if (cmd_end.finish) begin
          if (is_rw && !r.tc_seen && !(tc_agree && r.sync_tc[2])) begin
            next_r.end_of_cyl_flag = 1'b1;
          end
          any_err = next_r.equipment_fault_flag ||
                    next_r.end_of_cyl_flag ||
                    next_r.crc_fault_flag ||
                    next_r.overrun_flag ||
                    next_r.sector_not_found_flag ||
                    next_r.write_protect_hit_flag ||
                    next_r.mark_missing_flag ||
                    next_r.deleted_mark_seen_flag ||
                    next_r.cylinder_mismatch_flag;
          if (cmd_end.invalid) begin
            next_r.completion_code = DRSE_CC_INVALID;
          end else if (cmd_end.poll_abort) begin
            next_r.completion_code = DRSE_CC_POLLING;
          end else if (any_err) begin
            next_r.completion_code = DRSE_CC_ABNORMAL;
          end else begin
            next_r.completion_code = DRSE_CC_NORMAL;
          end

          next_r.completion_status_byte = '0;
          next_r.completion_status_byte[DRSE_B0_CC_LO +: 2] = next_r.completion_code;
          next_r.completion_status_byte[DRSE_B0_SEEK] = next_r.seek_done_flag;
          next_r.completion_status_byte[DRSE_B0_EQUIP] = next_r.equipment_fault_flag;
          next_r.completion_status_byte[DRSE_B0_HEAD] = r.head;
          next_r.completion_status_byte[DRSE_B0_DRIVE_LO +: 2] = r.drive;

          next_r.transfer_error_status_byte = '0;
          next_r.transfer_error_status_byte[DRSE_B1_EOC] = next_r.end_of_cyl_flag;
          next_r.transfer_error_status_byte[DRSE_B1_CRC] = next_r.crc_fault_flag;
          next_r.transfer_error_status_byte[DRSE_B1_OVR] = next_r.overrun_flag;
          next_r.transfer_error_status_byte[DRSE_B1_NOSEC] = next_r.sector_not_found_flag;
          next_r.transfer_error_status_byte[DRSE_B1_WP] = next_r.write_protect_hit_flag;
          next_r.transfer_error_status_byte[DRSE_B1_MARK] = next_r.mark_missing_flag;

          next_r.media_mark_status_byte = '0;
          next_r.media_mark_status_byte[DRSE_B2_DEL] = next_r.deleted_mark_seen_flag;
          next_r.media_mark_status_byte[DRSE_B2_DCRC] = next_r.data_field_crc_flag;
          next_r.media_mark_status_byte[DRSE_B2_WCYL] = next_r.cylinder_mismatch_flag;
          next_r.media_mark_status_byte[DRSE_B2_BAD] = next_r.bad_track_flag;
          next_r.media_mark_status_byte[DRSE_B2_DMARK] = next_r.data_mark_missing_flag;

          next_r.state = DRSE_RESULT;
          next_r.rd_idx = 2'h0;
          next_r.result_byte = next_r.completion_status_byte;
        end
      end
      DRSE_RESULT: begin
        // Bytes leave only through the result sequence, one per read
        if (result_rd) begin
          next_r.result_valid = 1'b1;
          next_r.result_last = (r.rd_idx == 2'(DRSE_RESULT_BYTES - 1));
          unique case (r.rd_idx)
            2'h0: begin
              next_r.result_byte = r.completion_status_byte;
            end
            2'h1: begin
              next_r.result_byte = r.transfer_error_status_byte;
            end
            default: begin
              next_r.result_byte = r.media_mark_status_byte;
            end
          endcase
          if (r.rd_idx == 2'(DRSE_RESULT_BYTES - 1)) begin
            next_r.state = DRSE_IDLE;
            next_r.busy = 1'b0;
          end else begin
            next_r.rd_idx = r.rd_idx + 2'h1;
          end
        end
      end
      default: begin
        next_r.state = DRSE_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.state <= DRSE_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign result_byte = r.result_byte;
  assign result_valid = r.result_valid;
  assign result_last = r.result_last;
  assign busy = r.busy;

endmodule : drse_status_encoder

/* bench/drse_asserts.sv */
// Purpose: Result sequence checks for the status encoder
// Assumes: Sees only the encoder ports, one clock domain
// Notes: Byte position and command context tracked locally
`timescale 1ns/1ps
module drse_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire drse_pkg::drse_cmd_info_t cmd_info,
  input wire drse_pkg::drse_end_t cmd_end,
  input wire logic result_rd,
  input wire logic [7:0] result_byte,
  input wire logic result_valid,
  input wire logic result_last,
  input wire logic busy
);
  import drse_pkg::*;
  logic [1:0] pos;
  logic [2:0] ctx;
  logic [1:0] endf;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pos <= 2'h0;
      ctx <= 3'h0;
      endf <= 2'h0;
    end else begin
      if (result_last) pos <= 2'h0;
      else if (result_valid) pos <= pos + 2'h1;
      if (cmd_info.start && !busy) ctx <= {cmd_info.head, cmd_info.drive};
      if (cmd_end.finish && busy) endf <= {cmd_end.invalid, cmd_end.poll_abort};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  read_latency_a: assert property (result_valid |-> $past(result_rd))
    else $error("result byte without read");
  last_valid_a: assert property (result_last |-> result_valid && pos == 2'h2 && !busy)
    else $error("last byte out of place");
  busy_start_a: assert property ((cmd_info.start && !busy) |-> ##1 busy)
    else $error("busy missing after start");
  rsv_first_a: assert property ((result_valid && pos == 2'h0) |-> !result_byte[3])
    else $error("first byte unused bit set");
  rsv_second_a: assert property ((result_valid && pos == 2'h1) |-> !result_byte[6] && !result_byte[3])
    else $error("second byte unused bit set");
  rsv_third_a: assert property ((result_valid && pos == 2'h2) |-> (result_byte & 8'h8C) == 8'h0)
    else $error("third byte unused bit set");
  head_drive_a: assert property ((result_valid && pos == 2'h0) |-> result_byte[2:0] == ctx)
    else $error("head or drive echo wrong");
  invalid_code_a: assert property ((result_valid && pos == 2'h0 && endf[1]) |-> result_byte[7:6] == 2'h2)
    else $error("invalid code wrong");
  poll_code_a: assert property ((result_valid && pos == 2'h0 && endf == 2'h1) |-> result_byte[7:6] == 2'h3)
    else $error("polling code wrong");
endmodule : drse_asserts

/* bench/drse_host_model.sv */
// Purpose: Host that fetches the three result bytes
// Assumes: Read pulses change at the falling edge
// Notes: Gap input sets prompt or slow pacing
`timescale 1ns/1ps
module drse_host_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [3:0] gap,
  output logic result_rd
);
  initial begin
    result_rd = 1'h0;
    forever begin
      @(posedge go);
      for (int i = 0; i < 3; i++) begin
        repeat (gap + 1) @(negedge sys_clk);
        result_rd = 1'h1;
        @(negedge sys_clk);
        result_rd = 1'h0;
      end
    end
  end
endmodule : drse_host_model

/* bench/tb.sv */
// Purpose: Self-checking bench for the status encoder
// Assumes: Inputs change at the falling edge
// Notes: Expected bytes queued by driver, checked by monitor
`timescale 1ns/1ps
module tb;
  import drse_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  drse_cmd_info_t ci = '0;
  drse_event_t ev = '0;
  drse_event_t e;
  drse_end_t end_v = '0;
  logic tz = 1'h0;
  logic wp_pin = 1'h0;
  logic idx_pin = 1'h0;
  logic term_pin = 1'h1;
  logic go = 1'h0;
  logic [3:0] gap = 4'h0;
  logic rd, valid, last, busy, head_v;
  logic [1:0] drv_v;
  logic [7:0] rbyte;
  logic [8:0] exp_q[$];
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int tn = 0;
  always #4 sys_clk = ~sys_clk;
  drse_status_encoder i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_info(ci), .exec_evt(ev), .cmd_end(end_v),
    .internal_cyl(8'h05), .track_zero_in(tz), .write_protect_in(wp_pin), .index_pulse_in(idx_pin),
    .transfer_terminate_in(term_pin), .result_rd(rd), .result_byte(rbyte), .result_valid(valid),
    .result_last(last), .busy(busy));
  drse_host_model i_host (.sys_clk(sys_clk), .go(go), .gap(gap), .result_rd(rd));
  task automatic check(string nm, logic [8:0] exp, logic [8:0] got);
    cmp_count++;
    if (exp !== got) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  always @(negedge sys_clk) begin
    if (valid === 1'h1) begin
      if (exp_q.size() == 0) check("extra_byte", 9'h0, 9'h1FF);
      else check("result", exp_q.pop_front(), {last, rbyte});
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      conclude();
    end
  end
  task automatic begin_cmd(drse_cmd_t c, logic imp = 1'h0);
    @(negedge sys_clk);
    head_v = 1'($urandom);
    drv_v = 2'($urandom);
    gap = 4'($urandom % 4);
    ci = '{1'h1, c, imp, head_v, drv_v};
    @(negedge sys_clk);
    ci.start = 1'h0;
    @(negedge sys_clk);
    check("busy", 9'(busy), 9'h1);
    e = '0;
  endtask : begin_cmd
  task automatic pulse();
    @(negedge sys_clk);
    ev = e;
    @(negedge sys_clk);
    ev = '0;
  endtask : pulse
  task automatic end_cmd(logic seek_v, logic eq_flt, logic [7:0] b1, logic [7:0] b2, logic inv, logic pol);
    logic [1:0] code;
    int n;
    code = inv ? 2'h2 : pol ? 2'h3 : (eq_flt || b1 != 8'h0 || b2 != 8'h0) ? 2'h1 : 2'h0;
    exp_q.push_back({1'h0, code, seek_v, eq_flt, 1'h0, head_v, drv_v});
    exp_q.push_back({1'h0, b1});
    exp_q.push_back({1'h1, b2});
    @(negedge sys_clk);
    end_v = '{1'h1, inv, pol};
    @(negedge sys_clk);
    end_v = '0;
    go = 1'h1;
    n = 0;
    while (busy !== 1'h0 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    go = 1'h0;
    @(negedge sys_clk);
    check("busy_end", 9'(n < 100), 9'h1);
    check("queue", 9'(exp_q.size()), 9'h0);
    tn++;
    $display("test %0d done", tn);
  endtask : end_cmd
  initial begin
    void'($urandom(32'hFD0F));
    repeat (4) @(negedge sys_clk);
    rst_n = 1'h1;
    repeat (4) @(negedge sys_clk);
    begin_cmd(DRSE_CMD_SEEK);
    e.seek_complete = 1'h1;
    pulse();
    end_cmd(1'h1, 1'h0, 8'h00, 8'h00, 1'h0, 1'h0);
    begin_cmd(DRSE_CMD_WRITE, 1'h1);
    e.seek_complete = 1'h1;
    pulse();
    end_cmd(1'h1, 1'h0, 8'h00, 8'h00, 1'h0, 1'h0);
    begin_cmd(DRSE_CMD_OTHER);
    end_cmd(1'h0, 1'h0, 8'h00, 8'h00, 1'h1, 1'h0);
    begin_cmd(DRSE_CMD_SEEK);
    end_cmd(1'h0, 1'h0, 8'h00, 8'h00, 1'h0, 1'h1);
    begin_cmd(DRSE_CMD_READ);
    e.data_crc_err = 1'h1;
    e.deleted_mark_seen = 1'h1;
    e.seek_complete = 1'h1;
    pulse();
    end_cmd(1'h0, 1'h0, 8'h20, 8'h60, 1'h0, 1'h0);
    begin_cmd(DRSE_CMD_READ_DEL);
    e.sector_missing = 1'h1;
    e.data_mark_seen = 1'h1;
    e.id_valid = 1'h1;
    e.id_cyl = 8'hFF;
    pulse();
    end_cmd(1'h0, 1'h0, 8'h04, 8'h52, 1'h0, 1'h0);
    begin_cmd(DRSE_CMD_WRITE);
    wp_pin = 1'h1;
    e.service_late = 1'h1;
    pulse();
    repeat (4) @(negedge sys_clk);
    end_cmd(1'h0, 1'h0, 8'h12, 8'h00, 1'h0, 1'h0);
    wp_pin = 1'h0;
    begin_cmd(DRSE_CMD_READ);
    e.data_mark_missing = 1'h1;
    pulse();
    end_cmd(1'h0, 1'h0, 8'h01, 8'h01, 1'h0, 1'h0);
    begin_cmd(DRSE_CMD_READ_ID);
    e.id_read_fail = 1'h1;
    pulse();
    repeat (2) begin
      idx_pin = 1'h1;
      repeat (4) @(negedge sys_clk);
      idx_pin = 1'h0;
      repeat (4) @(negedge sys_clk);
    end
    end_cmd(1'h0, 1'h0, 8'h05, 8'h00, 1'h0, 1'h0);
    begin_cmd(DRSE_CMD_READ_TRACK);
    e.sequence_fail = 1'h1;
    e.sector_past_end = 1'h1;
    e.sector_num = 8'hFF;
    e.id_crc_err = 1'h1;
    pulse();
    end_cmd(1'h0, 1'h0, 8'hA4, 8'h00, 1'h0, 1'h0);
    term_pin = 1'h0;
    repeat (5) @(negedge sys_clk);
    begin_cmd(DRSE_CMD_WRITE);
    end_cmd(1'h0, 1'h0, 8'h80, 8'h00, 1'h0, 1'h0);
    term_pin = 1'h1;
    repeat (5) @(negedge sys_clk);
    for (int k = 79; k <= 80; k++) begin
      begin_cmd(DRSE_CMD_RECAL);
      e.step_pulse = 1'h1;
      repeat (k) pulse();
      end_cmd(1'h0, 1'(k == 80), 8'h00, 8'h00, 1'h0, 1'h0);
    end
    tz = 1'h1;
    repeat (5) @(negedge sys_clk);
    begin_cmd(DRSE_CMD_RECAL);
    e.step_pulse = 1'h1;
    repeat (80) pulse();
    end_cmd(1'h0, 1'h0, 8'h00, 8'h00, 1'h0, 1'h0);
    tz = 1'h0;
    begin_cmd(DRSE_CMD_REL_SEEK);
    e.step_out_past_zero = 1'h1;
    pulse();
    end_cmd(1'h0, 1'h1, 8'h00, 8'h00, 1'h0, 1'h0);
    conclude();
  end
endmodule : tb
bind drse_status_encoder drse_asserts i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_info(cmd_info),
  .cmd_end(cmd_end), .result_rd(result_rd), .result_byte(result_byte), .result_valid(result_valid),
  .result_last(result_last), .busy(busy));
